/* rtl/sld_top.sv */
`timescale 1ns/1ps
`include "sld_consts.svh"

// Summary of operation
// - A rising edge of the shift clock puts the serial input into the bit buffer, which feeds the first stage; edges while it is full are dropped.
// - Each bit taken from the buffer moves every stage one place toward the serial output; else nothing moves.
// - The serial output shows the last stage so further devices can be chained.
// - While the strobe is high all stages are copied into their latches in parallel.
// - Latches follow the stages while the strobe is high and until the bits buffered at its fall have shifted in, then hold.
// - With output enable low each driver output shows its own latch.
// - With output enable high every driver output is forced low.
// - Output enable never touches the stages or the latches, it only gates the drivers.
// - There are eight latches, one per driver, sharing one strobe and one output enable.
module sld_top import sld_pkg::*; #(
  parameter int STAGES     = `SLD_STAGES,
  parameter int FIFO_DEPTH = `SLD_FIFO_DEPTH,
  parameter int SHIFT_DIV  = `SLD_SHIFT_DIV
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_B,
  // Host pins
  input  wire logic              SDI,
  input  wire logic              SCLK,
  input  wire logic              STRB,
  input  wire logic              OUT_EN_B,
  // Drivers
  output logic      [STAGES-1:0] DRV,
  // Cascade and flow
  output logic                   SDO,
  output logic                   BIT_RDY
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync <= `SLD_RSTS_RST;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ****************************************************************
  // State
  // ****************************************************************
  localparam int DW = (SHIFT_DIV > 1) ? $clog2(SHIFT_DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(SHIFT_DIV - 1);
  localparam int FW = $clog2(FIFO_DEPTH + 1);

  typedef struct packed {
    sld_pins_t         meta;
    sld_pins_t         sync;
    logic              sclk_prev;
    logic [DW-1:0]     div;
    logic              tick;
    logic [STAGES-1:0] sr;
    logic              open;
    logic [FW-1:0]     fill;
    logic [FW-1:0]     pend;
    logic [STAGES-1:0] latch;
    logic [STAGES-1:0] drv;
    logic              sdo;
    logic              rdy;
  } sld_top_s;

  sld_top_s s;
  sld_top_s next_s;

  // Named views of the synchronised pins
  logic sdi_s;
  logic sclk_s;
  logic strb_s;
  logic oe_s;

  assign sdi_s  = s.sync[`SLD_PIN_SDI];
  assign sclk_s = s.sync[`SLD_PIN_SCLK];
  assign strb_s = s.sync[`SLD_PIN_STRB];
  assign oe_s   = s.sync[`SLD_PIN_OE];

  // ****************************************************************
  // Bit buffer between edge detector and shift stages
  // ****************************************************************
  logic sclk_rise;
  logic fill_ready;
  logic drain_valid;
  logic drain_ready;
  logic drain_bit;
  logic drain_fire;
  logic fill_push;

  assign sclk_rise   = sclk_s && !s.sclk_prev;
  assign fill_push   = sclk_rise && fill_ready;
  assign drain_ready = s.tick;
  assign drain_fire  = drain_valid && drain_ready;

  sld_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_bits (
    .clk       (CLK),
    .rst_n     (rst_n),
    .in_valid  (sclk_rise),
    .in_ready  (fill_ready),
    .in_data   (sdi_s),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_bit)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    // Pins sampled twice; host setup and hold keep the data steady at the edge
    next_s.meta      = {OUT_EN_B, STRB, SCLK, SDI};
    next_s.sync      = s.meta;
    next_s.sclk_prev = sclk_s;

    // Shift pacing; a slower rate lets the buffer really fill
    if (s.div == DIV_LAST) begin
      next_s.div  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div  = s.div + 1'b1;
      next_s.tick = 1'b0;
    end

    if (drain_fire) begin
      next_s.sr = {s.sr[STAGES-2:0], drain_bit};
    end

    // Count buffered bits; those taken before the strobe fell still reach the latch
    next_s.fill = s.fill + FW'(fill_push) - FW'(drain_fire);
    if (strb_s) begin
      next_s.pend = next_s.fill;
    end else if (drain_fire && (s.pend != '0)) begin
      next_s.pend = s.pend - 1'b1;
    end
    // Bits arriving after the fall never reopen it
    next_s.open = strb_s || (s.pend != '0);
    if (next_s.open) begin
      next_s.latch = next_s.sr;
    end

    // Enable gates the drivers only
    next_s.drv = oe_s ? '0 : next_s.latch;
    next_s.sdo = next_s.sr[STAGES-1];
    next_s.rdy = fill_ready;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      // Enable held inactive so drivers stay off until loaded
      s.meta      <= `SLD_SYNC_RST;
      s.sync      <= `SLD_SYNC_RST;
      s.sclk_prev <= 1'b0;
      s.div       <= '0;
      s.tick      <= 1'b0;
      s.sr        <= STAGES'(`SLD_DATA_RST);
      s.open      <= 1'b0;
      s.fill      <= '0;
      s.pend      <= '0;
      s.latch     <= STAGES'(`SLD_DATA_RST);
      s.drv       <= STAGES'(`SLD_DATA_RST);
      s.sdo       <= 1'b0;
      s.rdy       <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign DRV     = s.drv;
  assign SDO     = s.sdo;
  assign BIT_RDY = s.rdy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_shift_in: assert property (
    @(posedge CLK) disable iff (!rst_n)
    drain_fire |=> (s.sr[0] == $past(drain_bit)) &&
                   (s.sr[STAGES-1:1] == $past(s.sr[STAGES-2:0]))
  ) else $error("shift stage did not take the buffered bit");

  chk_shift_hold: assert property (
    @(posedge CLK) disable iff (!rst_n)
    !drain_fire |=> $stable(s.sr)
  ) else $error("shift stages moved without a clock edge");

  chk_cascade_out: assert property (
    @(posedge CLK) disable iff (!rst_n)
    drain_fire |=> (SDO == $past(s.sr[STAGES-2]))
  ) else $error("serial output does not follow last stage");

  chk_latch_closed: assert property (
    @(posedge CLK) disable iff (!rst_n)
    (!strb_s && (s.pend == '0)) |=> $stable(s.latch)
  ) else $error("latch moved after strobe fell");

  chk_pend_bound: assert property (
    @(posedge CLK) disable iff (!rst_n)
    s.pend <= s.fill
  ) else $error("pending count beyond buffered bits");

  chk_strobe_open: assert property (
    @(posedge CLK) disable iff (!rst_n)
    strb_s |=> s.open && (s.latch == s.sr)
  ) else $error("latch not copying stages under strobe");

  chk_latch_hold: assert property (
    @(posedge CLK) disable iff (!rst_n)
    (!s.open ##1 !s.open) |-> $stable(s.latch)
  ) else $error("closed latch changed");

  chk_out_active: assert property (
    @(posedge CLK) disable iff (!rst_n)
    !oe_s |=> DRV == $past(next_s.latch)
  ) else $error("enabled drivers do not show latches");

  chk_out_disabled: assert property (
    @(posedge CLK) disable iff (!rst_n)
    oe_s |=> DRV == '0
  ) else $error("disabled drivers not low");

  chk_enable_isolated: assert property (
    @(posedge CLK) disable iff (!rst_n)
    ($changed(oe_s) && !drain_fire && !s.open && !strb_s) |=> $stable(s.sr) && $stable(s.latch)
  ) else $error("enable disturbed stages or latches");

  chk_edge_buffered: assert property (
    @(posedge CLK) disable iff (!rst_n)
    (sclk_rise && fill_ready && !drain_valid) |=> drain_valid
  ) else $error("clock edge not captured into buffer");

endmodule

/* rtl/sld_consts.svh */
`ifndef SLD_CONSTS_SVH
`define SLD_CONSTS_SVH

// ****************************************************************
// Shape of the driver
// ****************************************************************
`define SLD_STAGES      8
`define SLD_FIFO_DEPTH  4
`define SLD_SHIFT_DIV   1

// ****************************************************************
// Pin slots in the synchroniser vector
// ****************************************************************
`define SLD_PINS        4
`define SLD_PIN_SDI     0
`define SLD_PIN_SCLK    1
`define SLD_PIN_STRB    2
`define SLD_PIN_OE      3

// ****************************************************************
// Reset values
// ****************************************************************
`define SLD_SYNC_RST    4'h8
`define SLD_DATA_RST    8'h00
`define SLD_RSTS_RST    2'h0
`define SLD_RSTS_ON     2'h3

`endif

/* rtl/sld_pkg.sv */
`include "sld_consts.svh"

package sld_pkg;

  typedef logic [`SLD_STAGES-1:0] sld_word_t;
  typedef logic [`SLD_PINS-1:0]   sld_pins_t;

endpackage

/* rtl/sld_fifo.sv */
`timescale 1ns/1ps
`include "sld_consts.svh"

module sld_fifo import sld_pkg::*; #(
  parameter int WIDTH = 1,
  parameter int DEPTH = `SLD_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } sld_fifo_s;

  sld_fifo_s s;
  sld_fifo_s next_s;
  logic      push;
  logic      pop;

  assign in_ready  = (s.cnt != CNT_FULL);
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp        = (s.wp == PTR_LAST) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == PTR_LAST) ? '0 : s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

/* tb/sld_host.sv */
`timescale 1ns/1ps

module sld_host (
  // Clock and flow
  input  wire logic CLK,
  input  wire logic BIT_RDY,
  // Host pins
  output logic      SDI,
  output logic      SCLK,
  output logic      STRB,
  output logic      OUT_EN_B
);
  bit stalled;

  // ****************************************************************
  // Pin defaults
  // ****************************************************************
  initial begin
    stalled  = 1'b0;
    SDI      = 1'h0;
    SCLK     = 1'h0;
    STRB     = 1'h0;
    OUT_EN_B = 1'h1;
  end

  // ****************************************************************
  // Link traffic, 125 ns per bit, free of CLK phase
  // ****************************************************************
  task automatic send_bit(input logic b, input bit pace);
    int n;
    n = 0;
    while (pace && BIT_RDY !== 1'b1 && n < 2000) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (n >= 2000) begin
      stalled = 1'b1;
    end
    SDI = b;
    #62.5;
    SCLK = 1'b1;
    #62.5; // held through the rise
    SCLK = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] v, input bit pace);
    #3.3;
    for (int i = 7; i >= 0; i--) begin
      send_bit(v[i], pace);
    end
  endtask

  // ****************************************************************
  // Control pins, moved just after a CLK edge
  // ****************************************************************
  task automatic set_oe(input logic v);
    @(posedge CLK);
    #1 OUT_EN_B = v;
  endtask

  task automatic set_strb(input logic v);
    @(posedge CLK);
    #1 STRB = v;
  endtask

  task automatic pulse_strb();
    set_strb(1'b1);
    repeat (12) @(posedge CLK);
    set_strb(1'b0);
  endtask
endmodule

/* tb/sld_top_tb_top.sv */
`timescale 1ns/1ps
`include "sld_consts.svh"

module sld_top_tb_top import sld_pkg::*;;
  // Slow drain so the bit buffer can really fill
  localparam int SHIFT_DIV = 24;
  localparam int SETTLE    = (`SLD_FIFO_DEPTH + 2) * SHIFT_DIV + 16;

  logic      CLK;
  logic      RST_B;
  logic      SDI;
  logic      SCLK;
  logic      STRB;
  logic      OUT_EN_B;
  logic      SDO;
  logic      BIT_RDY;
  sld_word_t DRV;
  sld_word_t exp;
  int        n_fail;
  int        cmp_count;
  bit        rdy_low_seen;

  sld_top #(
    .SHIFT_DIV (SHIFT_DIV)
  ) u_sld_top (
    .CLK      (CLK),
    .RST_B    (RST_B),
    .SDI      (SDI),
    .SCLK     (SCLK),
    .STRB     (STRB),
    .OUT_EN_B (OUT_EN_B),
    .DRV      (DRV),
    .SDO      (SDO),
    .BIT_RDY  (BIT_RDY)
  );

  sld_host u_sld_host (
    .CLK      (CLK),
    .BIT_RDY  (BIT_RDY),
    .SDI      (SDI),
    .SCLK     (SCLK),
    .STRB     (STRB),
    .OUT_EN_B (OUT_EN_B)
  );

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    if (RST_B === 1'b1 && BIT_RDY === 1'b0) begin
      rdy_low_seen = 1'b1;
    end
  end

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    wait_clk(16);
    check("drv in reset", DRV, 8'h00);
    check("rdy in reset", {7'h00, BIT_RDY}, 8'h00);
    RST_B = 1'b1;
    wait_clk(4);
    check("rdy after reset", {7'h00, BIT_RDY}, 8'h01);
  endtask

  task automatic t_load();
    u_sld_host.send_byte(8'ha5, 1'b1);
    wait_clk(SETTLE);
    check("sdo a5", {7'h00, SDO}, 8'h01);
    u_sld_host.pulse_strb();
    wait_clk(6);
    check("drv oe off", DRV, 8'h00);
    u_sld_host.set_oe(1'b0);
    wait_clk(6);
    check("drv a5", DRV, 8'ha5);
  endtask

  task automatic t_hold();
    u_sld_host.send_byte(8'h3c, 1'b1);
    wait_clk(SETTLE);
    check("drv held", DRV, 8'ha5);
    check("sdo 3c", {7'h00, SDO}, 8'h00);
    u_sld_host.set_oe(1'b1);
    wait_clk(6);
    check("drv gated", DRV, 8'h00);
    u_sld_host.set_oe(1'b0);
    wait_clk(6);
    check("drv kept", DRV, 8'ha5);
    u_sld_host.pulse_strb();
    wait_clk(6);
    check("drv 3c", DRV, 8'h3c);
  endtask

  // Strobe left open, drivers gated while bits move
  task automatic t_follow();
    logic [3:0] pat;
    pat = 4'h9;
    exp = 8'h3c;
    u_sld_host.set_oe(1'b1);
    u_sld_host.set_strb(1'b1);
    for (int i = 0; i < 4; i++) begin
      u_sld_host.send_bit(pat[i], 1'b1);
      wait_clk(SETTLE);
      exp = {exp[6:0], pat[i]};
      check("drv follow gated", DRV, 8'h00);
      check("sdo follow", {7'h00, SDO}, {7'h00, exp[7]});
      u_sld_host.set_oe(1'b0);
      wait_clk(6);
      check("drv follow", DRV, exp);
      u_sld_host.set_oe(1'b1);
    end
    u_sld_host.set_strb(1'b0);
  endtask

  task automatic t_overflow();
    rdy_low_seen = 1'b0;
    u_sld_host.send_byte(8'hff, 1'b0);
    u_sld_host.send_byte(8'hff, 1'b0);
    check("rdy refused", {7'h00, rdy_low_seen}, 8'h01);
    wait_clk(SETTLE);
    check("rdy drained", {7'h00, BIT_RDY}, 8'h01);
    u_sld_host.send_byte(8'h81, 1'b1);
    wait_clk(SETTLE);
    u_sld_host.pulse_strb();
    u_sld_host.set_oe(1'b0);
    wait_clk(6);
    check("drv 81", DRV, 8'h81);
  endtask

  initial begin
    RST_B        = 1'b0;
    n_fail       = 0;
    cmp_count    = 0;
    rdy_low_seen = 1'b0;
    t_reset();
    t_load();
    t_hold();
    t_follow();
    t_overflow();
    check("host stall", {7'h00, u_sld_host.stalled}, 8'h00);
    wrap_up();
  end

  // Whole run needs well under 500 us of CLK time
  initial begin
    #500000;
    n_fail++;
    wrap_up();
  end
endmodule
